// file: hdl/scm_pkg.sv
// constants and state types for the sync connector label router
package scm_pkg;
  // user pin configuration codes
  localparam logic [1:0] PIN_CFG_OUTPUT = 2'h0;
  localparam logic [1:0] PIN_CFG_IN_ONE = 2'h1;
  localparam logic [1:0] PIN_CFG_IN_TWO = 2'h2;
  // sync output source select codes
  localparam logic [3:0] OUT_CONST_LOW = 4'h0;
  localparam logic [3:0] OUT_CONST_HIGH = 4'h1;
  localparam logic [3:0] OUT_PIN_ZERO = 4'h2;
  localparam logic [3:0] OUT_PIN_ONE = 4'h3;
  localparam logic [3:0] OUT_IN_ONE = 4'h4;
  localparam logic [3:0] OUT_IN_TWO = 4'h5;
  localparam logic [3:0] OUT_START = 4'h6;
  localparam logic [3:0] OUT_SECOND = 4'h7;
  localparam logic [3:0] OUT_TIMECODE_CHECK = 4'h8;
  // label mode codes
  localparam logic [4:0] LABEL_OFF = 5'h00;
  localparam logic [4:0] LABEL_ONE_RISE = 5'h01;
  localparam logic [4:0] LABEL_ONE_FALL = 5'h02;
  localparam logic [4:0] LABEL_TWO_RISE = 5'h03;
  localparam logic [4:0] LABEL_TWO_FALL = 5'h04;
  localparam logic [4:0] LABEL_INTERNAL = 5'h05;
  localparam logic [4:0] LABEL_TC_ONE = 5'h10;
  localparam logic [4:0] LABEL_TC_ONE_INV = 5'h11;
  localparam logic [4:0] LABEL_TC_TWO = 5'h12;
  localparam logic [4:0] LABEL_TC_TWO_INV = 5'h13;
  // timing
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint SECOND_NS = 1000000000;
  localparam longint TC_MARK_MIN_US = 6500;
  localparam longint TC_LOSS_S = 2;
  localparam longint SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam longint TC_MARK_CYCLES =
    (TC_MARK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint TC_LOSS_CYCLES = TC_LOSS_S * SECOND_CYCLES;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] filt;
    logic start_lbl;
    logic sec_lbl;
    logic sec_run;
    logic [31:0] sec_cnt;
    logic tc_lvl;
    logic [31:0] tc_hcnt;
    logic tc_prev_mark;
    logic tc_ready;
    logic tc_sec;
    logic [31:0] tc_wd;
    logic out_one;
    logic out_two;
    logic pin0_o;
    logic pin0_oe;
    logic pin1_o;
    logic pin1_oe;
  } scm_state_s;
endpackage

// file: hdl/scm_router.sv
// sync connector routing, label generation and time-code second decoding
// Notes on behaviour
// - pin code 0 output, 1 driven from sync in one, 2 from two
// - pin codes only act when custom firmware is loaded
// - select 0 drives low, 1 drives high; low after reset
// - select 2 routes user pin zero, 3 routes user pin one
// - select 4 passes sync in one, 5 passes sync in two
// - select 6 pulses on every start label
// - select 7 pulses on every second label
// - select 8: output one decoder ready, output two decoded second
// - mode 0 generates no label
// - mode 1 rising edge of input one, mode 3 of input two
// - mode 2 falling edge of input one, mode 4 of input two
// - internal start mode: one label per start command only
// - internal second mode: timer label each second after start command
// - mode 16 decoder on input one, second labels only
// - mode 18 decoder on input two uninverted
// - modes 17 and 19 feed decoder inverted input one or two
module scm_router #(
  parameter logic [31:0] SEC_CYC = 32'(scm_pkg::SECOND_CYCLES),
  parameter logic [31:0] MARK_CYC = 32'(scm_pkg::TC_MARK_CYCLES),
  parameter logic [31:0] LOSS_CYC = 32'(scm_pkg::TC_LOSS_CYCLES)
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sync_in_one,
  input wire logic sync_in_two,
  input wire logic custom_firmware,
  input wire logic [1:0] user_pin_config_zero,
  input wire logic [1:0] user_pin_config_one,
  input wire logic user_pin_zero_i,
  output logic user_pin_zero_o,
  output logic user_pin_zero_oe,
  input wire logic user_pin_one_i,
  output logic user_pin_one_o,
  output logic user_pin_one_oe,
  input wire logic [3:0] sync_out_source_select_one,
  input wire logic [3:0] sync_out_source_select_two,
  input wire logic [4:0] start_label_mode,
  input wire logic [4:0] second_label_mode,
  input wire logic start_label_command,
  input wire logic second_label_start_command,
  output logic sync_out_one,
  output logic sync_out_two,
  output logic start_label,
  output logic second_label,
  output logic timecode_ready
);
  scm_pkg::scm_state_s st_q, st_d;
  logic [3:0] edges;
  logic tc_in, tc_on, is_mark;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic edge_event(input logic [4:0] m,
                                      input logic [3:0] e);
    logic r;
    r = 1'b0;
    case (m)
      scm_pkg::LABEL_ONE_RISE: r = e[0];
      scm_pkg::LABEL_TWO_RISE: r = e[2];
      scm_pkg::LABEL_ONE_FALL: r = e[1];
      scm_pkg::LABEL_TWO_FALL: r = e[3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic route(input logic [3:0] sel, input logic second,
                                 input scm_pkg::scm_state_s s,
                                 input logic p0, input logic p1);
    logic r;
    r = 1'b0;
    case (sel)
      scm_pkg::OUT_CONST_LOW: r = 1'b0;
      scm_pkg::OUT_CONST_HIGH: r = 1'b1;
      scm_pkg::OUT_PIN_ZERO: r = p0;
      scm_pkg::OUT_PIN_ONE: r = p1;
      scm_pkg::OUT_IN_ONE: r = s.filt[0];
      scm_pkg::OUT_IN_TWO: r = s.filt[1];
      scm_pkg::OUT_START: r = s.start_lbl;
      scm_pkg::OUT_SECOND: r = s.sec_lbl;
      scm_pkg::OUT_TIMECODE_CHECK: r = second ? s.tc_sec : s.tc_ready;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    // three stages; a change counts once stages two and three agree
    st_d.sync1 = {sync_in_two, sync_in_one};
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    for (int i = 0; i < 2; i++) begin
      if (st_q.sync2[i] == st_q.sync3[i]) begin
        st_d.filt[i] = st_q.sync3[i];
      end
    end
    edges = {~st_d.filt[1] & st_q.filt[1], st_d.filt[1] & ~st_q.filt[1],
             ~st_d.filt[0] & st_q.filt[0], st_d.filt[0] & ~st_q.filt[0]};

    // decoder input select; decoder idles outside its modes
    tc_on = 1'b1;
    case (second_label_mode)
      scm_pkg::LABEL_TC_ONE: tc_in = st_q.filt[0];
      scm_pkg::LABEL_TC_ONE_INV: tc_in = ~st_q.filt[0];
      scm_pkg::LABEL_TC_TWO: tc_in = st_q.filt[1];
      scm_pkg::LABEL_TC_TWO_INV: tc_in = ~st_q.filt[1];
      default: begin
        tc_in = 1'b0;
        tc_on = 1'b0;
      end
    endcase
    // two marker pulses in a row mark the second; pulse seen at its end
    is_mark = st_q.tc_hcnt >= MARK_CYC;
    st_d.tc_lvl = tc_in;
    st_d.tc_sec = 1'b0;
    if (tc_in && !st_q.tc_lvl) begin
      st_d.tc_hcnt = '0;
    end else if (tc_in && st_q.tc_hcnt != '1) begin
      st_d.tc_hcnt = st_q.tc_hcnt + 32'h0000_0001;
    end
    if (!tc_in && st_q.tc_lvl) begin
      if (is_mark && st_q.tc_prev_mark) begin
        st_d.tc_sec = 1'b1;
        st_d.tc_ready = 1'b1;
        st_d.tc_prev_mark = 1'b0;
      end else begin
        st_d.tc_prev_mark = is_mark;
      end
    end
    if (st_d.tc_sec) begin
      st_d.tc_wd = '0;
    end else if (st_q.tc_wd >= LOSS_CYC) begin
      st_d.tc_ready = 1'b0;
    end else begin
      st_d.tc_wd = st_q.tc_wd + 32'h0000_0001;
    end
    if (!tc_on) begin
      st_d.tc_hcnt = '0;
      st_d.tc_prev_mark = 1'b0;
      st_d.tc_ready = 1'b0;
      st_d.tc_sec = 1'b0;
      st_d.tc_wd = '0;
    end

    // one per second timer; a new command restarts the phase
    if (second_label_mode != scm_pkg::LABEL_INTERNAL) begin
      st_d.sec_run = 1'b0;
      st_d.sec_cnt = '0;
    end else if (second_label_start_command) begin
      st_d.sec_run = 1'b1;
      st_d.sec_cnt = '0;
    end else if (st_q.sec_run) begin
      if (st_q.sec_cnt == SEC_CYC - 32'h0000_0001) begin
        st_d.sec_cnt = '0;
      end else begin
        st_d.sec_cnt = st_q.sec_cnt + 32'h0000_0001;
      end
    end

    // decoder modes are not valid start sources and fall to off
    if (start_label_mode == scm_pkg::LABEL_INTERNAL) begin
      st_d.start_lbl = start_label_command;
    end else begin
      st_d.start_lbl = edge_event(start_label_mode, edges);
    end
    if (second_label_mode == scm_pkg::LABEL_INTERNAL) begin
      st_d.sec_lbl = st_q.sec_run && !second_label_start_command &&
        st_q.sec_cnt == SEC_CYC - 32'h0000_0001;
    end else if (tc_on) begin
      st_d.sec_lbl = st_d.tc_sec;
    end else begin
      st_d.sec_lbl = edge_event(second_label_mode, edges);
    end

    // standard firmware ignores the pin codes: pins stay outputs
    st_d.pin0_oe = custom_firmware &&
      user_pin_config_zero != scm_pkg::PIN_CFG_OUTPUT;
    st_d.pin1_oe = custom_firmware &&
      user_pin_config_one != scm_pkg::PIN_CFG_OUTPUT;
    st_d.pin0_o = user_pin_config_zero == scm_pkg::PIN_CFG_IN_TWO ?
      st_q.filt[1] : st_q.filt[0];
    st_d.pin1_o = user_pin_config_one == scm_pkg::PIN_CFG_IN_TWO ?
      st_q.filt[1] : st_q.filt[0];
    st_d.out_one = route(sync_out_source_select_one, 1'b0, st_q,
                         user_pin_zero_i, user_pin_one_i);
    st_d.out_two = route(sync_out_source_select_two, 1'b1, st_q,
                         user_pin_zero_i, user_pin_one_i);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out_one = st_q.out_one;
  assign sync_out_two = st_q.out_two;
  assign user_pin_zero_o = st_q.pin0_o;
  assign user_pin_zero_oe = st_q.pin0_oe;
  assign user_pin_one_o = st_q.pin1_o;
  assign user_pin_one_oe = st_q.pin1_oe;
  assign start_label = st_q.start_lbl;
  assign second_label = st_q.sec_lbl;
  assign timecode_ready = st_q.tc_ready;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_pin_in;
    custom_firmware && user_pin_config_zero == scm_pkg::PIN_CFG_IN_TWO
      |=> user_pin_zero_oe && user_pin_zero_o == $past(st_q.filt[1]);
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("pin not driven");

  property p_std_fw;
    !custom_firmware |=> !user_pin_zero_oe && !user_pin_one_oe;
  endproperty
  a_std_fw: assert property (p_std_fw) else $error("pin drive");

  property p_const;
    sync_out_source_select_one == scm_pkg::OUT_CONST_HIGH |=> sync_out_one;
  endproperty
  a_const: assert property (p_const) else $error("not high");

  property p_pin_route;
    sync_out_source_select_two == scm_pkg::OUT_PIN_ONE
      |=> sync_out_two == $past(user_pin_one_i);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin route");

  property p_start_out;
    sync_out_source_select_one == scm_pkg::OUT_START
      |=> sync_out_one == $past(start_label);
  endproperty
  a_start_out: assert property (p_start_out) else $error("start out");

  property p_off;
    start_label_mode == scm_pkg::LABEL_OFF |=> !start_label;
  endproperty
  a_off: assert property (p_off) else $error("label while off");

  property p_rise;
    start_label_mode == scm_pkg::LABEL_ONE_RISE ##1 $rose(st_q.filt[0])
      |-> start_label;
  endproperty
  a_rise: assert property (p_rise) else $error("rise missed");

  property p_cmd;
    start_label_mode == scm_pkg::LABEL_INTERNAL
      |=> start_label == $past(start_label_command);
  endproperty
  a_cmd: assert property (p_cmd) else $error("start cmd");

  property p_pulse;
    start_label |=> !start_label ||
      $past(start_label_mode) == scm_pkg::LABEL_INTERNAL;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long label");

  property p_tc_sec;
    second_label_mode == scm_pkg::LABEL_TC_TWO && st_d.tc_sec
      |=> second_label && timecode_ready;
  endproperty
  a_tc_sec: assert property (p_tc_sec) else $error("tc second");

  property p_in_pass;
    sync_out_source_select_two == scm_pkg::OUT_IN_TWO
      |=> sync_out_two == $past(st_q.filt[1]);
  endproperty
  a_in_pass: assert property (p_in_pass) else $error("input pass");

  property p_second_out;
    sync_out_source_select_two == scm_pkg::OUT_SECOND
      |=> sync_out_two == $past(second_label);
  endproperty
  a_second_out: assert property (p_second_out) else $error("sec out");

  property p_tc_check;
    sync_out_source_select_one == scm_pkg::OUT_TIMECODE_CHECK
      |=> sync_out_one == $past(timecode_ready);
  endproperty
  a_tc_check: assert property (p_tc_check) else $error("tc check");

  property p_fall;
    start_label_mode == scm_pkg::LABEL_TWO_FALL ##1 $fell(st_q.filt[1])
      |-> start_label;
  endproperty
  a_fall: assert property (p_fall) else $error("fall missed");

  property p_sec_off;
    second_label_mode == scm_pkg::LABEL_OFF |=> !second_label;
  endproperty
  a_sec_off: assert property (p_sec_off) else $error("sec off");

  // decoder codes are second-only; a start source must stay silent
  property p_tc_start;
    start_label_mode >= scm_pkg::LABEL_TC_ONE |=> !start_label;
  endproperty
  a_tc_start: assert property (p_tc_start) else $error("tc start");

  property p_pin_out;
    user_pin_config_one == scm_pkg::PIN_CFG_OUTPUT |=> !user_pin_one_oe;
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin out");
endmodule // scm_router

// file: tb/scm_sync_equipment.sv
// external sync equipment model driving the two connector inputs
module scm_sync_equipment #(
  parameter int MARK = 8
) (
  input wire logic clk_sys,
  output logic line_one,
  output logic line_two
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    line_one = 1'b0;
    line_two = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic hold(input bit two, input bit v, input int n);
    if (two) line_two <= v;
    else line_one <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  // whole pulses only, so rises and falls pair up
  task automatic pulses(input int n1, input int n2);
    for (int i = 0; i < n1; i++) begin
      hold(0, 1, 6);
      hold(0, 0, 6);
    end
    for (int i = 0; i < n2; i++) begin
      hold(1, 1, 6);
      hold(1, 0, 6);
    end
  endtask
  // marker pair then short bits; inv puts the inverted level on the line
  task automatic frames(input bit two, input bit inv);
    for (int f = 0; f < 3; f++) begin
      for (int k = 0; k < 2; k++) begin
        hold(two, !inv, MARK + 4);
        hold(two, inv, 6);
      end
      for (int k = 0; k < 3; k++) begin
        hold(two, !inv, 3);
        hold(two, inv, 5);
      end
    end
  endtask
endmodule // scm_sync_equipment

// file: tb/scm_router_test.sv
// self-checking bench for the sync connector label router
module scm_router_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEC = 50;
  logic clk_sys = 0, rst_n = 0, fw = 0, proc0 = 0, proc1 = 0;
  logic scmd = 0, tcmd = 0, s_lbl, t_lbl, out1, out2, ready;
  logic o0, oe0, o1, oe1, in1, in2, p_s, p_t, e1, e2;
  logic [1:0] cfg = 2'h0;
  logic [3:0] sel1 = 4'h0, sel2 = 4'h0;
  logic [4:0] smode = 5'h00, tmode = 5'h00;
  int bad_count = 0, compares = 0, n_s, n_t, n_o1, n_o2, r1, r2;
  wire pin0 = oe0 ? o0 : proc0;
  wire pin1 = oe1 ? o1 : proc1;
  initial forever #20 clk_sys = ~clk_sys;
  scm_sync_equipment #(.MARK(8)) eq_u (.clk_sys(clk_sys),
    .line_one(in1), .line_two(in2));
  // short counts keep the run small
  scm_router #(.SEC_CYC(32'(SEC)), .MARK_CYC(32'h0000_0008),
    .LOSS_CYC(32'h0000_00c8)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .sync_in_one(in1), .sync_in_two(in2), .custom_firmware(fw),
    .user_pin_config_zero(cfg), .user_pin_config_one(cfg),
    .user_pin_zero_i(pin0), .user_pin_zero_o(o0), .user_pin_zero_oe(oe0),
    .user_pin_one_i(pin1), .user_pin_one_o(o1), .user_pin_one_oe(oe1),
    .sync_out_source_select_one(sel1), .sync_out_source_select_two(sel2),
    .start_label_mode(smode), .second_label_mode(tmode),
    .start_label_command(scmd), .second_label_start_command(tcmd),
    .sync_out_one(out1), .sync_out_two(out2), .start_label(s_lbl),
    .second_label(t_lbl), .timecode_ready(ready));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic exp_out(int s, logic a, b, p, q);
    case (s)
      1: return 1'b1;
      2: return p;
      3: return q;
      4: return a;
      5: return b;
      default: return 1'b0;
    endcase
  endfunction
  function automatic int exp_lbl(int m, int a, int b);
    return (m == 1 || m == 2) ? a : (m == 3 || m == 4) ? b : 0;
  endfunction
  // cleared on the falling edge to stay clear of the counting edge
  task automatic clr();
    @(negedge clk_sys);
    {n_s, n_t, n_o1, n_o2} = '0;
    @(posedge clk_sys);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (s_lbl) chk(32'(p_s), 0);
    if (t_lbl) chk(32'(p_t), 0);
    n_s += s_lbl;
    n_t += t_lbl;
    n_o1 += out1;
    n_o2 += out2;
    p_s = s_lbl;
    p_t = t_lbl;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(35064));
    tick(3);
    rst_n <= 1'b1;
    tick(1);
    chk(32'(out1), 0);
    chk(32'(oe0), 0);
    for (int s = 0; s < 10; s++) begin
      {proc0, proc1} <= 2'($urandom);
      sel1 <= 4'(s);
      sel2 <= 4'(9 - s);
      eq_u.hold($urandom_range(0, 1), $urandom_range(0, 1), 1);
      tick(8);
      e1 = exp_out(s, in1, in2, pin0, pin1);
      e2 = exp_out(9 - s, in1, in2, pin0, pin1);
      chk(32'(out1), 32'(e1));
      chk(32'(out2), 32'(e2));
    end
    for (int c = 1; c < 6; c++) begin
      fw <= c > 2;
      cfg <= 2'(c % 3);
      eq_u.hold(0, 1, 1);
      eq_u.hold(1, 0, 8);
      chk(32'({oe0, oe1}), (c % 3 && c > 2) ? 3 : 0);
      if (c > 3) chk(32'({o0, o1}), (c == 4) ? 3 : 0);
    end
    sel1 <= 4'h6;
    sel2 <= 4'h7;
    for (int m = 0; m < 5; m++) begin
      smode <= 5'(m);
      tmode <= 5'(m);
      r1 = $urandom_range(1, 4);
      r2 = $urandom_range(1, 4);
      clr();
      eq_u.pulses(r1, r2);
      tick(10);
      chk(32'(n_s), exp_lbl(m, r1, r2));
      chk(32'(n_t), exp_lbl(m, r1, r2));
      chk(32'(n_o1), exp_lbl(m, r1, r2));
      chk(32'(n_o2), exp_lbl(m, r1, r2));
    end
    smode <= 5'h05;
    tmode <= 5'h05;
    clr();
    // commands are single-cycle pulses: one start label each; tcmd starts the timer
    scmd <= 1'b1;
    tick(1);
    scmd <= 1'b0;
    tick(5);
    scmd <= 1'b1;
    tcmd <= 1'b1;
    tick(1);
    {scmd, tcmd} <= 2'h0;
    tick(SEC - 5);
    chk(32'(n_s), 2);
    chk(32'(n_t), 0);
    tick(2 * SEC + 10);
    chk(32'(n_t), 3);
    chk(32'(n_s), 2);
    sel1 <= 4'h8;
    sel2 <= 4'h8;
    for (int m = 16; m < 20; m++) begin
      smode <= 5'(m);
      tmode <= 5'(m);
      eq_u.hold(m > 17, m % 2, 20);
      clr();
      eq_u.frames(m > 17, m % 2);
      for (r1 = 0; r1 < 100 && ready !== 1'b1; r1++) tick(1);
      if (r1 == 100) begin
        bad_count++;
        final_report();
      end
      chk(32'(out1), 1);
      chk(32'(n_t > 0 && n_o2 == n_t), 1);
      chk(32'(n_s), 0);
      tmode <= 5'h00;
      tick(4);
      chk(32'(ready), 0);
    end
    final_report();
  end
endmodule // scm_router_test
